// ==== chsf_card_model.sv ====
module chsf_card_model (
    output logic o_clk,   // Card clock, still between frames
    output logic o_cmd,   // Command line, pulled up
    output logic o_dat0,  // Data line 0, pulled up
    output logic o_dat1   // Data line 1, pulled up
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {o_clk, o_cmd, o_dat0, o_dat1} = 4'h7;
    // Drive levels for n card clocks, then the pull-ups take the lines
    task frame(input logic cmd, input logic d0, input logic d1, input int n);
        #5; // Keep pin edges off the system clock edges
        {o_cmd, o_dat0, o_dat1} = {cmd, d0, d1};
        repeat (n) begin
            #100 o_clk = 1'b1;
            #100 o_clk = 1'b0;
        end
        {o_cmd, o_dat0, o_dat1} = 3'h7;
    endtask
endmodule

// ==== chsf_map.svh ====
`ifndef CHSF_MAP_SVH
`define CHSF_MAP_SVH

// Register byte offsets
`define CHSF_OFS_CMD        6'h00
`define CHSF_OFS_BLKCNT     6'h04
`define CHSF_OFS_CTRL       6'h08
`define CHSF_OFS_STATUS     6'h0c
`define CHSF_OFS_CLEAR      6'h10
`define CHSF_OFS_ENABLE     6'h14
`define CHSF_OFS_RXCNT      6'h18
`define CHSF_OFS_RXNEXT     6'h1c
`define CHSF_OFS_TXCNT      6'h20
`define CHSF_OFS_TXNEXT     6'h24

// Command register fields
`define CHSF_CMD_IDX_LSB    0
`define CHSF_CMD_IDX_W      6
`define CHSF_CMD_TYPE_LSB   8
`define CHSF_CMD_TYPE_W     3
`define CHSF_STOP_CMD_IDX   6'h0c

// Control register bits
`define CHSF_CTRL_W         3
`define CHSF_CTRL_RDWAIT    0
`define CHSF_CTRL_CEATA     1
`define CHSF_CTRL_SDIO      2

// Status, clear and enable register bits
`define CHSF_STAT_W         19
`define CHSF_ST_IDLE        0
`define CHSF_ST_RXDONE      1
`define CHSF_ST_TXDONE      2
`define CHSF_ST_RXEXH       3
`define CHSF_ST_TXEXH       4
`define CHSF_ST_SLOTA       5
`define CHSF_ST_RDWAIT      6
`define CHSF_ST_CMPL        7
`define CHSF_ST_RINDEX      8
`define CHSF_ST_RTO         9
`define CHSF_ST_DCRC        10
`define CHSF_ST_DTO         11
`define CHSF_ST_CTO         12
`define CHSF_ST_QDRAIN      13
`define CHSF_ST_XFER        14
`define CHSF_ST_BACK        15
`define CHSF_ST_BACKERR     16
`define CHSF_ST_OVR         17
`define CHSF_ST_UNR         18
`define CHSF_MASK_LEVEL     19'h00059
`define CHSF_MASK_RDCLR     19'h000a0

// Reset values
`define CHSF_RST_IDLE       1'b1
`define CHSF_RST_WAITREQ    1'b1
`define CHSF_RST_ENABLE     19'h00000
`define CHSF_RST_CTRL       3'h0

`endif

// ==== chsf_pkg.sv ====
package chsf_pkg;

    typedef enum logic [2:0] {
        CHSF_ST_IDLE_S = 3'b000,
        CHSF_ST_CMD_S  = 3'b001,
        CHSF_ST_DATA_S = 3'b011,
        CHSF_ST_STOP_S = 3'b010,
        CHSF_ST_BUSY_S = 3'b110
    } chsf_state_t;

    typedef enum logic [2:0] {
        CHSF_XT_NONE     = 3'h0,
        CHSF_XT_SINGLE   = 3'h1,
        CHSF_XT_MULTI    = 3'h2,
        CHSF_XT_INFINITE = 3'h3,
        CHSF_XT_BUSY     = 3'h4
    } chsf_xfer_t;

endpackage

// ==== chsf_status.sv ====
// Behaviour
// - Any read: idle flag drops once the host command has been issued.
// - Open-ended multi-block read: idle flag rises only when stop command completes.
// - Single-block read: idle flag rises after the one block is received.
// - Counted multi-block read: idle flag rises after the last expected block.
// - Idle flag 0 from response end, 1 when card releases busy on data line.
// - Receive count done sets at counter zero; writing either receive counter clears.
// - Transmit count done sets at counter zero; writing either transmit counter clears.
// - Receive exhausted is 1 exactly when both receive counters are zero.
// - Transmit exhausted is 1 exactly when both transmit counters are zero.
// - Slot A card interrupt sets on detection; status read clears it.
// - Read wait status is 1 while data bus is held in wait state.
// - Completion signal seen sets on command-line completion; status read clears it.
// - Response index mismatch flags error; writing command register clears it.
// - Separate enables for response, data CRC, data and completion timeouts.
// - Separate enables for queue drained, transfer, boot ack, boot error, overrun, underrun.
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`include "chsf_map.svh"

module chsf_status
    import chsf_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic        i_clk_sys,           // System clock, 40 MHz
    input  wire logic        i_reset,             // Synchronous reset, active high
    input  wire logic [5:0]  i_avs_address,       // Byte address
    input  wire logic        i_avs_read,          // Read request
    input  wire logic        i_avs_write,         // Write request
    input  wire logic [31:0] i_avs_writedata,     // Write data
    input  wire logic [3:0]  i_avs_byteenable,    // Write byte lanes
    output logic             o_avs_waitrequest,   // Low on the accepting edge
    output logic      [31:0] o_avs_readdata,      // Read data
    output logic             o_irq,               // Level interrupt
    input  wire logic        i_card_clk,          // Card clock pin
    input  wire logic        i_card_cmd,          // Command line pin
    input  wire logic        i_card_dat0,         // Data line 0 pin, busy
    input  wire logic        i_card_dat1,         // Data line 1 pin, interrupt
    input  wire logic        i_cmd_issued,        // Host command fully sent
    input  wire logic        i_resp_done,         // Card response ended
    input  wire logic [5:0]  i_resp_index,        // Index in that response
    input  wire logic        i_block_end,         // One data block received
    input  wire logic        i_rx_dma_beat,       // Receive DMA transfer
    input  wire logic        i_tx_dma_beat,       // Transmit DMA transfer
    input  wire logic        i_evt_resp_timeout,  // Response timeout
    input  wire logic        i_evt_data_crc,      // Data CRC error
    input  wire logic        i_evt_data_timeout,  // Data timeout
    input  wire logic        i_evt_cmpl_timeout,  // Completion timeout
    input  wire logic        i_evt_queue_drained, // Queue drained
    input  wire logic        i_evt_xfer_complete, // Transfer complete
    input  wire logic        i_evt_boot_ack,      // Boot ack received
    input  wire logic        i_evt_boot_ack_err,  // Boot ack error
    input  wire logic        i_evt_overrun,       // Overrun
    input  wire logic        i_evt_underrun,      // Underrun
    output logic             o_cmd_start,         // Pulse: command written
    output logic      [5:0]  o_cmd_index,         // Index of last command
    output logic             o_data_path_idle,    // Data path idle flag
    output logic             o_read_wait_status   // Hold data bus in wait
);
    typedef struct packed {
        logic                    waitreq;
        logic [31:0]             rdata;
        logic                    irq;
        logic                    cmd_start;
        logic [5:0]              cmd_index;
        chsf_xfer_t              xfer;
        logic [CNT_W-1:0]        blkcnt;
        logic [CNT_W-1:0]        blk_seen;
        logic [`CHSF_CTRL_W-1:0] ctrl;
        chsf_state_t             state;
        logic                    idle;
        logic                    rdwait;
        logic [`CHSF_STAT_W-1:0] sticky;
        logic [`CHSF_STAT_W-1:0] enable;
        logic [CNT_W-1:0]        rx_cnt;
        logic [CNT_W-1:0]        rx_next;
        logic [CNT_W-1:0]        tx_cnt;
        logic [CNT_W-1:0]        tx_next;
        logic                    clk_prev;
    } chsf_regs_t;

    chsf_regs_t s_r;
    chsf_regs_t s_nxt;
    logic [3:0] pins_sync;

    chsf_sync #(
        .W (4)
    ) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_async   ({i_card_dat1, i_card_dat0, i_card_cmd, i_card_clk}),
        .o_sync    (pins_sync)
    );

    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Level bits are live views of state; only event bits are stored
    function automatic logic [`CHSF_STAT_W-1:0] status_view(input chsf_regs_t r);
        logic [`CHSF_STAT_W-1:0] v;
        v                  = r.sticky & ~`CHSF_MASK_LEVEL;
        v[`CHSF_ST_IDLE]   = r.idle;
        v[`CHSF_ST_RXEXH]  = (r.rx_cnt == '0) && (r.rx_next == '0);
        v[`CHSF_ST_TXEXH]  = (r.tx_cnt == '0) && (r.tx_next == '0);
        v[`CHSF_ST_RDWAIT] = r.rdwait;
        return v;
    endfunction

    logic                    req;
    logic                    accept;
    logic                    wr_acc;
    logic                    rd_status;
    logic [31:0]             wmerged;
    logic [31:0]             rd_mux;
    logic                    card_rise;
    logic [`CHSF_STAT_W-1:0] evt;
    logic [`CHSF_STAT_W-1:0] clr;
    logic                    stop_write;
    chsf_xfer_t              new_xfer;

    always_comb begin
        s_nxt      = s_r;
        req        = i_avs_read | i_avs_write;
        accept     = req & ~s_r.waitreq;
        wr_acc     = accept & i_avs_write;
        rd_status  = accept & i_avs_read & (i_avs_address == `CHSF_OFS_STATUS);
        evt        = '0;
        clr        = '0;
        stop_write = 1'b0;
        new_xfer   = CHSF_XT_NONE;
        rd_mux     = 32'h0000_0000;
        wmerged    = 32'h0000_0000;

        // One wait cycle per access: data is prepared while waitrequest is high
        s_nxt.waitreq   = ~(req & s_r.waitreq);
        s_nxt.cmd_start = 1'b0;

        s_nxt.clk_prev = pins_sync[0];
        card_rise      = pins_sync[0] & ~s_r.clk_prev;

        unique case (i_avs_address)
            `CHSF_OFS_CMD:    rd_mux = {21'h0, s_r.xfer, 2'h0, s_r.cmd_index};
            `CHSF_OFS_BLKCNT: rd_mux = 32'(s_r.blkcnt);
            `CHSF_OFS_CTRL:   rd_mux = 32'(s_r.ctrl);
            `CHSF_OFS_STATUS: rd_mux = 32'(status_view(s_r));
            `CHSF_OFS_ENABLE: rd_mux = 32'(s_r.enable);
            `CHSF_OFS_RXCNT:  rd_mux = 32'(s_r.rx_cnt);
            `CHSF_OFS_RXNEXT: rd_mux = 32'(s_r.rx_next);
            `CHSF_OFS_TXCNT:  rd_mux = 32'(s_r.tx_cnt);
            `CHSF_OFS_TXNEXT: rd_mux = 32'(s_r.tx_next);
            default:          rd_mux = 32'h0000_0000;
        endcase
        // Captured in the wait cycle, so it stands at the accepting edge
        if (req && s_r.waitreq) begin
            s_nxt.rdata = i_avs_read ? rd_mux : 32'h0000_0000;
        end

        // Only bits already returned are cleared, so late events stay set
        if (rd_status) begin
            clr = clr | (s_r.rdata[`CHSF_STAT_W-1:0] & `CHSF_MASK_RDCLR);
        end

        if (wr_acc) begin
            wmerged = merge_be(rd_mux, i_avs_writedata, i_avs_byteenable);
            unique case (i_avs_address)
                `CHSF_OFS_CMD: begin
                    s_nxt.cmd_index   = wmerged[`CHSF_CMD_IDX_LSB +: `CHSF_CMD_IDX_W];
                    new_xfer          = chsf_xfer_t'(wmerged[`CHSF_CMD_TYPE_LSB +:
                                                             `CHSF_CMD_TYPE_W]);
                    s_nxt.cmd_start   = 1'b1;
                    clr[`CHSF_ST_RINDEX] = 1'b1;
                    stop_write = (s_nxt.cmd_index == `CHSF_STOP_CMD_IDX);
                end
                `CHSF_OFS_BLKCNT: s_nxt.blkcnt = wmerged[CNT_W-1:0];
                `CHSF_OFS_CTRL:   s_nxt.ctrl   = wmerged[`CHSF_CTRL_W-1:0];
                `CHSF_OFS_CLEAR:  clr = clr | (i_avs_writedata[`CHSF_STAT_W-1:0]
                                               & ~`CHSF_MASK_LEVEL);
                `CHSF_OFS_ENABLE: s_nxt.enable = wmerged[`CHSF_STAT_W-1:0]
                                                 & ~`CHSF_MASK_LEVEL
                                                 | wmerged[`CHSF_STAT_W-1:0]
                                                 & `CHSF_MASK_LEVEL;
                `CHSF_OFS_RXCNT: begin
                    s_nxt.rx_cnt = wmerged[CNT_W-1:0];
                    clr[`CHSF_ST_RXDONE] = 1'b1;
                end
                `CHSF_OFS_RXNEXT: begin
                    s_nxt.rx_next = wmerged[CNT_W-1:0];
                    clr[`CHSF_ST_RXDONE] = 1'b1;
                end
                `CHSF_OFS_TXCNT: begin
                    s_nxt.tx_cnt = wmerged[CNT_W-1:0];
                    clr[`CHSF_ST_TXDONE] = 1'b1;
                end
                `CHSF_OFS_TXNEXT: begin
                    s_nxt.tx_next = wmerged[CNT_W-1:0];
                    clr[`CHSF_ST_TXDONE] = 1'b1;
                end
                default: ;
            endcase
        end

        // DMA counters: a beat that empties the counter reloads from next
        if (i_rx_dma_beat && s_r.rx_cnt != '0 && !(wr_acc
                && (i_avs_address == `CHSF_OFS_RXCNT
                    || i_avs_address == `CHSF_OFS_RXNEXT))) begin
            s_nxt.rx_cnt = s_r.rx_cnt - CNT_W'(1);
            if (s_nxt.rx_cnt == '0) begin
                evt[`CHSF_ST_RXDONE] = 1'b1;
                s_nxt.rx_cnt  = s_r.rx_next;
                s_nxt.rx_next = '0;
            end
        end
        if (i_tx_dma_beat && s_r.tx_cnt != '0 && !(wr_acc
                && (i_avs_address == `CHSF_OFS_TXCNT
                    || i_avs_address == `CHSF_OFS_TXNEXT))) begin
            s_nxt.tx_cnt = s_r.tx_cnt - CNT_W'(1);
            if (s_nxt.tx_cnt == '0) begin
                evt[`CHSF_ST_TXDONE] = 1'b1;
                s_nxt.tx_cnt  = s_r.tx_next;
                s_nxt.tx_next = '0;
            end
        end

        // Card-side detections; slot A and completion are taken on card clock rising edges
        if (card_rise && s_r.ctrl[`CHSF_CTRL_SDIO] && !pins_sync[3]
                && s_r.state != CHSF_ST_DATA_S) begin
            evt[`CHSF_ST_SLOTA] = 1'b1;
        end
        if (card_rise && s_r.ctrl[`CHSF_CTRL_CEATA] && !pins_sync[1]
                && s_r.state == CHSF_ST_IDLE_S) begin
            evt[`CHSF_ST_CMPL] = 1'b1;
        end
        if (i_resp_done && (i_resp_index != s_r.cmd_index)) begin
            evt[`CHSF_ST_RINDEX] = 1'b1;
        end

        evt[`CHSF_ST_RTO]     = i_evt_resp_timeout;
        evt[`CHSF_ST_DCRC]    = i_evt_data_crc;
        evt[`CHSF_ST_DTO]     = i_evt_data_timeout;
        evt[`CHSF_ST_CTO]     = i_evt_cmpl_timeout;
        evt[`CHSF_ST_QDRAIN]  = i_evt_queue_drained;
        evt[`CHSF_ST_XFER]    = i_evt_xfer_complete;
        evt[`CHSF_ST_BACK]    = i_evt_boot_ack;
        evt[`CHSF_ST_BACKERR] = i_evt_boot_ack_err;
        evt[`CHSF_ST_OVR]     = i_evt_overrun;
        evt[`CHSF_ST_UNR]     = i_evt_underrun;

        // Set wins over clear, for every sticky bit
        s_nxt.sticky = ((s_r.sticky & ~clr) | evt) & ~`CHSF_MASK_LEVEL;

        // Data path sequencing
        unique case (s_r.state)
            CHSF_ST_IDLE_S: begin
                if (s_nxt.cmd_start && new_xfer != CHSF_XT_NONE) begin
                    s_nxt.xfer     = new_xfer;
                    s_nxt.blk_seen = '0;
                    s_nxt.state    = CHSF_ST_CMD_S;
                end
            end
            CHSF_ST_CMD_S: begin
                if (s_r.xfer == CHSF_XT_BUSY) begin
                    if (i_resp_done) begin
                        s_nxt.idle  = 1'b0;
                        s_nxt.state = CHSF_ST_BUSY_S;
                    end
                end else if (i_cmd_issued) begin
                    s_nxt.idle  = 1'b0;
                    s_nxt.state = CHSF_ST_DATA_S;
                end
            end
            CHSF_ST_DATA_S: begin
                if (s_r.xfer == CHSF_XT_INFINITE && stop_write) begin
                    s_nxt.state = CHSF_ST_STOP_S;
                end else if (i_block_end) begin
                    s_nxt.blk_seen = s_r.blk_seen + CNT_W'(1);
                    if (s_r.xfer == CHSF_XT_SINGLE) begin
                        s_nxt.idle  = 1'b1;
                        s_nxt.state = CHSF_ST_IDLE_S;
                    end else if (s_r.xfer == CHSF_XT_MULTI
                                 && s_nxt.blk_seen == s_r.blkcnt) begin
                        s_nxt.idle  = 1'b1;
                        s_nxt.state = CHSF_ST_IDLE_S;
                    end
                end
            end
            CHSF_ST_STOP_S: begin
                if (i_resp_done) begin
                    s_nxt.idle  = 1'b1;
                    s_nxt.state = CHSF_ST_IDLE_S;
                end
            end
            CHSF_ST_BUSY_S: begin
                if (card_rise && pins_sync[2]) begin
                    s_nxt.idle  = 1'b1;
                    s_nxt.state = CHSF_ST_IDLE_S;
                end
            end
            default: begin
                s_nxt.state = CHSF_ST_IDLE_S;
            end
        endcase

        // Wait state for the whole data state of a read in progress
        s_nxt.rdwait = s_nxt.ctrl[`CHSF_CTRL_RDWAIT]
                       && s_nxt.state == CHSF_ST_DATA_S;

        s_nxt.irq = |(status_view(s_nxt) & s_nxt.enable);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            s_r         <= '0;
            s_r.waitreq <= `CHSF_RST_WAITREQ;
            s_r.idle    <= `CHSF_RST_IDLE;
            s_r.enable  <= `CHSF_RST_ENABLE;
            s_r.ctrl    <= `CHSF_RST_CTRL;
            s_r.state   <= CHSF_ST_IDLE_S;
            s_r.xfer    <= CHSF_XT_NONE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_avs_waitrequest  = s_r.waitreq;
    assign o_avs_readdata     = s_r.rdata;
    assign o_irq              = s_r.irq;
    assign o_cmd_start        = s_r.cmd_start;
    assign o_cmd_index        = s_r.cmd_index;
    assign o_data_path_idle   = s_r.idle;
    assign o_read_wait_status = s_r.rdwait;
endmodule

// ==== chsf_status_asserts.sv ====
`include "chsf_map.svh"

module chsf_status_asserts (
    input wire logic        i_clk_sys,          // System clock
    input wire logic        i_reset,            // Synchronous reset
    input wire logic [5:0]  i_avs_address,      // Byte address
    input wire logic        i_avs_read,         // Read request
    input wire logic        i_avs_write,        // Write request
    input wire logic [31:0] i_avs_writedata,    // Write data
    input wire logic        o_avs_waitrequest,  // Wait request
    input wire logic        i_cmd_issued,       // Command sent
    input wire logic        i_resp_done,        // Response ended
    input wire logic        i_block_end,        // Block received
    input wire logic        i_card_dat0,        // Data line 0 pin
    input wire logic        o_cmd_start,        // Command pulse
    input wire logic [5:0]  o_cmd_index,        // Last command index
    input wire logic        o_data_path_idle,   // Idle flag
    input wire logic        o_read_wait_status  // Read wait level
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    sequence s_req_wait;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_cmd_take;
        i_avs_write && !o_avs_waitrequest && i_avs_address == `CHSF_OFS_CMD;
    endsequence

    wait_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    answer_cause_a: assert property ($fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write))
        else $error("access answered without a request");
    answer_time_a: assert property (s_req_wait |=> !o_avs_waitrequest)
        else $error("request not answered after one wait cycle");
    cmd_pulse_a: assert property (s_cmd_take |-> ##[1:2] o_cmd_start)
        else $error("command write gave no start pulse");
    cmd_index_a: assert property (
        s_cmd_take ##2 1'b1 |-> o_cmd_index == $past(i_avs_writedata[5:0], 2))
        else $error("command index not taken from the write");
    idle_drop_a: assert property (
        $fell(o_data_path_idle) |-> $past(i_cmd_issued) || $past(i_resp_done))
        else $error("idle flag fell without command or response end");
    idle_rise_a: assert property (
        $rose(o_data_path_idle) |->
            $past(i_block_end) || $past(i_resp_done) || $past(i_card_dat0, 3))
        else $error("idle flag rose without a cause");
    wait_in_data_a: assert property ($rose(o_read_wait_status) |-> !o_data_path_idle)
        else $error("read wait outside a data transfer");
endmodule

bind chsf_status chsf_status_asserts u_chk (.i_clk_sys, .i_reset, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .o_avs_waitrequest, .i_cmd_issued, .i_resp_done,
    .i_block_end, .i_card_dat0, .o_cmd_start, .o_cmd_index, .o_data_path_idle,
    .o_read_wait_status);

// ==== chsf_status_test.sv ====
`include "chsf_map.svh"

module chsf_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [5:0]  addr = 6'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic        wreq, irq, cmd_start, idle, rwait;
    logic [31:0] rdata, st;
    logic [5:0]  cmd_idx;
    logic [5:0]  ridx = 6'h00;
    logic [14:0] pl = 15'h0;
    logic        cclk, ccmd, cd0, cd1;
    int          n_fail = 0;
    int          tests_run = 0;

    always #12.5 clk = ~clk;

    chsf_card_model u_card (.o_clk(cclk), .o_cmd(ccmd), .o_dat0(cd0), .o_dat1(cd1));

    chsf_status DUT (.i_clk_sys(clk), .i_reset(rst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
        .o_avs_waitrequest(wreq), .o_avs_readdata(rdata), .o_irq(irq), .i_card_clk(cclk),
        .i_card_cmd(ccmd), .i_card_dat0(cd0), .i_card_dat1(cd1), .i_cmd_issued(pl[0]),
        .i_resp_done(pl[1]), .i_resp_index(ridx), .i_block_end(pl[2]), .i_rx_dma_beat(pl[3]),
        .i_tx_dma_beat(pl[4]), .i_evt_resp_timeout(pl[5]), .i_evt_data_crc(pl[6]),
        .i_evt_data_timeout(pl[7]), .i_evt_cmpl_timeout(pl[8]), .i_evt_queue_drained(pl[9]),
        .i_evt_xfer_complete(pl[10]), .i_evt_boot_ack(pl[11]), .i_evt_boot_ack_err(pl[12]),
        .i_evt_overrun(pl[13]), .i_evt_underrun(pl[14]), .o_cmd_start(cmd_start),
        .o_cmd_index(cmd_idx), .o_data_path_idle(idle), .o_read_wait_status(rwait));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Hold the request until the edge that sees waitrequest low
    task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        st = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task pls(input int i);
        @(posedge clk);
        pl[i] <= 1'b1;
        @(posedge clk);
        pl[i] <= 1'b0;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task t_reset;
        acc(1'b1, 6'h3c, 32'hffffffff);
        acc(1'b0, 6'h3c, 32'h0);
        chk(st, 32'h0);
        acc(1'b0, `CHSF_OFS_STATUS, 32'h0);
        chk(st, 32'h19);
        acc(1'b0, `CHSF_OFS_ENABLE, 32'h0);
        chk(st, 32'h0);
        chk(irq, 1'b0);
    endtask

    task t_dma;
        for (int k = 0; k < 2; k++) begin
            acc(1'b1, 6'h18 + 6'(8 * k), 32'h2);
            acc(1'b1, 6'h1c + 6'(8 * k), 32'h1);
            pls(3 + k);
            pls(3 + k);
            acc(1'b0, `CHSF_OFS_STATUS, 32'h0);
            chk({st[1 + k], st[3 + k]}, 2'b10);
            pls(3 + k);
            acc(1'b0, `CHSF_OFS_STATUS, 32'h0);
            chk(st[3 + k], 1'b1);
            acc(1'b1, 6'h1c + 6'(8 * k), 32'h0);
            acc(1'b0, `CHSF_OFS_STATUS, 32'h0);
            chk({st[1 + k], st[3 + k]}, 2'b01);
        end
    endtask

    task t_events;
        for (int i = 0; i < 10; i++) begin
            acc(1'b1, `CHSF_OFS_ENABLE, 32'h1 << (9 + i));
            pls(5 + i);
            cyc(2);
            chk(irq, 1'b1);
            acc(1'b1, `CHSF_OFS_CLEAR, 32'h1 << (9 + i));
            cyc(2);
            chk(irq, 1'b0);
        end
        acc(1'b1, `CHSF_OFS_ENABLE, 32'h0);
        pls(13);
        cyc(2);
        chk(irq, 1'b0);
        acc(1'b0, `CHSF_OFS_STATUS, 32'h0);
        chk(st[17], 1'b1);
    endtask

    task t_pins;
        acc(1'b1, `CHSF_OFS_CTRL, 32'h6);
        u_card.frame(1'b0, 1'b1, 1'b0, 2);
        cyc(8);
        acc(1'b0, `CHSF_OFS_STATUS, 32'h0);
        chk({st[7], st[5]}, 2'b11);
        acc(1'b0, `CHSF_OFS_STATUS, 32'h0);
        chk({st[7], st[5]}, 2'b00);
    endtask

    task t_reads;
        acc(1'b1, `CHSF_OFS_CTRL, 32'h1);
        acc(1'b1, `CHSF_OFS_CMD, 32'h111);
        @(negedge clk);
        chk(cmd_start, 1'b1);
        cyc(1);
        chk(cmd_start, 1'b0);
        chk(cmd_idx, 6'h11);
        pls(0);
        cyc(1);
        chk(idle, 1'b0);
        pls(2);
        cyc(1);
        chk(idle, 1'b1);
        acc(1'b1, `CHSF_OFS_BLKCNT, 32'h2);
        acc(1'b1, `CHSF_OFS_CMD, 32'h212);
        pls(0);
        pls(2);
        cyc(1);
        chk(idle, 1'b0);
        pls(2);
        cyc(1);
        chk(idle, 1'b1);
        acc(1'b1, `CHSF_OFS_CMD, 32'h312);
        pls(0);
        pls(2);
        pls(2);
        cyc(1);
        chk({idle, rwait}, 2'b01);
        acc(1'b0, `CHSF_OFS_STATUS, 32'h0);
        chk(st[6], 1'b1);
        acc(1'b1, `CHSF_OFS_CMD, 32'h00c);
        ridx <= 6'h0c;
        pls(1);
        cyc(1);
        chk({idle, rwait}, 2'b10);
        ridx <= 6'h05;
        pls(1);
        acc(1'b0, `CHSF_OFS_STATUS, 32'h0);
        chk(st[8], 1'b1);
        acc(1'b1, `CHSF_OFS_CMD, 32'h005);
        acc(1'b0, `CHSF_OFS_STATUS, 32'h0);
        chk(st[8], 1'b0);
    endtask

    task t_busy;
        acc(1'b1, `CHSF_OFS_CMD, 32'h418);
        ridx <= 6'h18;
        pls(1);
        cyc(1);
        chk(idle, 1'b0);
        u_card.frame(1'b1, 1'b0, 1'b1, 2);
        cyc(6);
        chk(idle, 1'b0);
        u_card.frame(1'b1, 1'b1, 1'b1, 2);
        cyc(6);
        chk(idle, 1'b1);
    endtask

    task wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Whole run needs a few hundred cycles
    initial begin
        #2000000;
        n_fail++;
        wrap_up;
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_dma;
        t_events;
        t_pins;
        t_reads;
        t_busy;
        wrap_up;
    end
endmodule

// ==== chsf_sync.sv ====
module chsf_sync #(
    parameter int W = 4
) (
    input  wire logic         i_clk_sys,  // System clock
    input  wire logic         i_reset,    // Synchronous reset, active high
    input  wire logic [W-1:0] i_async,    // Inputs from outside the domain
    output logic      [W-1:0] o_sync      // Two-stage synchronised copy
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } chsf_sync_t;

    chsf_sync_t s_r;
    chsf_sync_t s_nxt;

    always_comb begin
        s_nxt        = s_r;
        s_nxt.meta   = i_async;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_sync = s_r.stable;
endmodule
